// >>> hw/afq_consts.svh
// register offsets, field positions, reset values and sizes of the accel queue and trim block
`ifndef AFQ_CONSTS_SVH
`define AFQ_CONSTS_SVH
`define AFQ_ADDR_ZTRIM    8'h3a
`define AFQ_ADDR_SCR0     8'h3b
`define AFQ_ADDR_SCR1     8'h3c
`define AFQ_ADDR_CFG      8'h3e
`define AFQ_ADDR_DATA     8'h3f
`define AFQ_CFG_MODE_HI   7
`define AFQ_CFG_MODE_LO   6
`define AFQ_CFG_SEL_HI    1
`define AFQ_CFG_SEL_LO    0
`define AFQ_RST_BYTE      8'h00
`define AFQ_DEPTH         6'd32
`define AFQ_PTR_W         5
`define AFQ_LVL_W         6
`define AFQ_ING_DEPTH     8
`define AFQ_FRAME_W       48
`define AFQ_ACC_W         12
`define AFQ_LAST_XYZ      3'd5
`define AFQ_LAST_ONE      3'd1
`define AFQ_TRIM_SHIFT    2'd3
`endif

// >>> hw/afq_pkg.sv
// types shared by the accel queue and trim block
package afq_pkg;
   typedef enum logic [1:0] {
      AFQ_BYPASS                = 2'b00,
      AFQ_HOLD_FULL             = 2'b01,
      AFQ_CONTINUOUS_OVERWRITE  = 2'b10,
      AFQ_MODE_RSVD             = 2'b11
   } afq_mode_e;
   typedef enum logic [1:0] {
      AFQ_AXIS_XYZ = 2'b00,
      AFQ_AXIS_X   = 2'b01,
      AFQ_AXIS_Y   = 2'b10,
      AFQ_AXIS_Z   = 2'b11
   } afq_axis_e;
   typedef enum logic [1:0] {
      AFQ_COMP_NONE = 2'b00,
      AFQ_COMP_X    = 2'b01,
      AFQ_COMP_Y    = 2'b10,
      AFQ_COMP_Z    = 2'b11
   } afq_comp_e;
endpackage

// >>> hw/afq_ingress_fifo.sv
// small valid/ready frame buffer between the sensor datapath and the frame store
`timescale 1ns/1ns
module afq_ingress_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    head;
   logic [PW-1:0]    tail;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic             doIn;
   logic             doOut;

   assign doIn     = inValid && inReady;
   assign doOut    = outValid && outReady;
   assign outValid = count != '0;
   assign outData  = store[head];

   always_comb begin
      next_count = flush ? '0 : count + CW'(doIn) - CW'(doOut);
   end

   always_ff @(posedge core_clk) begin
      if (doIn) begin
         store[tail] <= inData;
      end
   end

   // ready is registered so the sensor side never sees a combinational path from the drain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         head    <= '0;
         tail    <= '0;
         count   <= '0;
         inReady <= 1'b0;
      end else begin
         count   <= next_count;
         inReady <= next_count != CW'(DEPTH);
         if (flush) begin
            head <= '0;
            tail <= '0;
         end else begin
            if (doIn) begin
               tail <= PW'(tail + 1'b1);
            end
            if (doOut) begin
               head <= PW'(head + 1'b1);
            end
         end
      end
   end

   a_never_overfills: assert property (@(posedge core_clk) disable iff (!rst_n) count <= CW'(DEPTH))
      else $error("ingress buffer count above depth");
endmodule

// >>> hw/afq_core.sv
// accelerometer z trim, nv-backed scratch bytes and 32-frame acceleration queue
// How it works
// (R1) signed 8-bit z trim is added to both filtered and unfiltered z data
// (R2) trim counts stay about 7.8 mg each whatever range is selected
// (R3) z trim reloads from its nv image after power-on and softreset
// (R4) z trim takes host writes and the fast compensation result for z
// (R5) two 8-bit scratch bytes, reset to zero, touching no sensor function
// (R6) each scratch byte reloads from its nv image after power-up and softreset
// (R7) any write to the queue config empties the queue and clears full
// (R8) mode 00b keeps one frame, each new frame replacing the last
// (R9) mode 01b stores up to 32 frames then refuses more while all 32 are held
// (R10) mode 10b keeps storing when full, dropping the oldest frame
// (R11) the host never writes the reserved mode 11b
// (R12) axis field picks xyz, x only, y only or z only per frame
// (R13) data port bytes match result register low/high format with new-data bit
// (R14) a burst at the data address keeps the address fixed
// (R15) a partly read frame is discarded whole at burst end
// (R16) xyz frames read as x low, x high, y low, y high, z low, z high
// (R17) single-axis frames read as low then high, frames back to back
// (R18) offset clear sets the z trim to zero
// (R19) trigger 11b with compensation ready starts a z run; never trigger when busy
// (R20) full flag rises at 32 frames and holds until a config write or softreset
// (R21) each fully read frame frees a slot; an empty queue reads zero
`timescale 1ns/1ns
`include "afq_consts.svh"
module afq_core (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  softReset,
   input  wire logic [7:0]            nvmZTrim,
   input  wire logic [7:0]            nvmScratchZero,
   input  wire logic [7:0]            nvmScratchOne,
   input  wire logic [7:0]            regAddr,
   input  wire logic                  regWrEn,
   input  wire logic [7:0]            regWrData,
   input  wire logic                  regRdEn,
   input  wire logic                  burstEnd,
   output logic      [7:0]            regRdData,
   output logic                       addrHold,
   input  wire logic                  offsetClear,
   input  wire logic [1:0]            compTrigger,
   input  wire logic                  compReady,
   input  wire logic                  compZDone,
   input  wire logic [7:0]            compZValue,
   output logic                       compStartZ,
   input  wire logic [1:0]            accRange,
   input  wire logic [`AFQ_ACC_W-1:0] accZFilt,
   input  wire logic [`AFQ_ACC_W-1:0] accZRaw,
   output logic      [`AFQ_ACC_W-1:0] zFiltTrimmed,
   output logic      [`AFQ_ACC_W-1:0] zRawTrimmed,
   input  wire logic                  sampleValid,
   output logic                       sampleReady,
   input  wire logic [15:0]           sampleX,
   input  wire logic [15:0]           sampleY,
   input  wire logic [15:0]           sampleZ,
   output logic      [7:0]            zTrim,
   output logic      [7:0]            scratchByteZero,
   output logic      [7:0]            scratchByteOne,
   output logic                       queueFull,
   output logic      [`AFQ_LVL_W-1:0] queueLevel
);
   logic [`AFQ_FRAME_W-1:0] frameMem [32];
   logic [`AFQ_PTR_W-1:0]   rdPtr;
   logic [`AFQ_PTR_W-1:0]   wrPtr;
   logic [`AFQ_PTR_W-1:0]   memAddr;
   logic [2:0]              byteIdx;
   logic                    restorePending;
   afq_pkg::afq_mode_e      cfgMode;
   afq_pkg::afq_axis_e      cfgAxis;
   logic                    cfgWrite;
   logic                    clearQ;
   logic                    dataRead;
   logic                    lastByte;
   logic                    frameBusy;
   logic                    popNow;
   logic                    pushReady;
   logic                    ingValid;
   logic [`AFQ_FRAME_W-1:0] ingData;
   logic                    push;
   logic                    memWe;
   logic                    queueAtTop;

   // trim scaled to data lsb: 7.8 mg per count is 8 lsb at the finest range, halving per range step
   function automatic logic [`AFQ_ACC_W-1:0] addTrim(input logic [`AFQ_ACC_W-1:0] data,
                                                     input logic [7:0] trim, input logic [1:0] range);
      logic signed [`AFQ_ACC_W:0] scaled;
      logic signed [`AFQ_ACC_W:0] sum;
      scaled = $signed({{(`AFQ_ACC_W-7){trim[7]}}, trim}) <<< (`AFQ_TRIM_SHIFT - range); // (R2)
      sum    = $signed({data[`AFQ_ACC_W-1], data}) + scaled; // (R1)
      if (sum[`AFQ_ACC_W] != sum[`AFQ_ACC_W-1]) begin
         addTrim = sum[`AFQ_ACC_W] ? {1'b1, {(`AFQ_ACC_W-1){1'b0}}} : {1'b0, {(`AFQ_ACC_W-1){1'b1}}};
      end else begin
         addTrim = sum[`AFQ_ACC_W-1:0];
      end
   endfunction

   // bytes carry the result register format untouched, new-data bit included
   function automatic logic [7:0] frameByte(input logic [`AFQ_FRAME_W-1:0] frame,
                                            input afq_pkg::afq_axis_e axis, input logic [2:0] idx);
      logic [15:0] word;
      word = 16'h0000;
      unique case (axis)
         afq_pkg::AFQ_AXIS_XYZ: frameByte = frame[{idx, 3'b000} +: 8]; // (R16) (R13)
         default: begin
            word      = frame[15:0]; // (R17)
            frameByte = idx[0] ? word[15:8] : word[7:0]; // (R17) (R13)
         end
      endcase
   endfunction

   // single-axis frames keep only the chosen axis, packed into the low word
   function automatic logic [`AFQ_FRAME_W-1:0] packFrame(input afq_pkg::afq_axis_e axis,
                                                        input logic [`AFQ_FRAME_W-1:0] full);
      unique case (axis)
         afq_pkg::AFQ_AXIS_XYZ: packFrame = full; // (R12)
         afq_pkg::AFQ_AXIS_X:   packFrame = {32'h0000_0000, full[15:0]}; // (R12)
         afq_pkg::AFQ_AXIS_Y:   packFrame = {32'h0000_0000, full[31:16]}; // (R12)
         afq_pkg::AFQ_AXIS_Z:   packFrame = {32'h0000_0000, full[47:32]}; // (R12)
      endcase
   endfunction

   assign cfgWrite   = regWrEn && regAddr == `AFQ_ADDR_CFG;
   assign clearQ     = cfgWrite || softReset; // (R7)
   assign dataRead   = regRdEn && regAddr == `AFQ_ADDR_DATA && queueLevel != '0;
   assign lastByte   = byteIdx == ((cfgAxis == afq_pkg::AFQ_AXIS_XYZ) ? `AFQ_LAST_XYZ : `AFQ_LAST_ONE);
   assign frameBusy  = byteIdx != 3'd0;
   assign popNow     = (dataRead && lastByte) || (burstEnd && frameBusy); // (R21) (R15)
   // new frames wait in the ingress buffer while a frame is being read, so bytes never mix frames
   assign pushReady  = !frameBusy && !dataRead && !clearQ;
   assign push       = ingValid && pushReady;
   assign queueAtTop = queueLevel == `AFQ_DEPTH;
   assign memAddr    = (cfgMode == afq_pkg::AFQ_BYPASS || cfgMode == afq_pkg::AFQ_MODE_RSVD) ? rdPtr : wrPtr;
   assign memWe      = push && !(cfgMode == afq_pkg::AFQ_HOLD_FULL && queueAtTop); // (R9)

   afq_ingress_fifo #(
      .WIDTH (`AFQ_FRAME_W),
      .DEPTH (`AFQ_ING_DEPTH)
   ) u_ingress (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .flush    (clearQ),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .inData   ({sampleZ, sampleY, sampleX}),
      .outValid (ingValid),
      .outReady (pushReady),
      .outData  (ingData)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         restorePending <= 1'b1;
      end else begin
         restorePending <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         zTrim <= `AFQ_RST_BYTE;
      end else if (restorePending || softReset) begin
         zTrim <= nvmZTrim; // (R3)
      end else if (offsetClear) begin
         zTrim <= `AFQ_RST_BYTE; // (R18)
      end else if (compZDone) begin
         zTrim <= compZValue; // (R4)
      end else if (regWrEn && regAddr == `AFQ_ADDR_ZTRIM) begin
         zTrim <= regWrData; // (R4)
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scratchByteZero <= `AFQ_RST_BYTE; // (R5)
         scratchByteOne  <= `AFQ_RST_BYTE; // (R5)
      end else if (restorePending || softReset) begin
         scratchByteZero <= nvmScratchZero; // (R6)
         scratchByteOne  <= nvmScratchOne; // (R6)
      end else if (regWrEn) begin
         if (regAddr == `AFQ_ADDR_SCR0) begin
            scratchByteZero <= regWrData; // (R5)
         end
         if (regAddr == `AFQ_ADDR_SCR1) begin
            scratchByteOne <= regWrData; // (R5)
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgMode <= afq_pkg::AFQ_BYPASS;
         cfgAxis <= afq_pkg::AFQ_AXIS_XYZ;
      end else if (softReset) begin
         cfgMode <= afq_pkg::AFQ_BYPASS;
         cfgAxis <= afq_pkg::AFQ_AXIS_XYZ;
      end else if (cfgWrite) begin
         cfgMode <= afq_pkg::afq_mode_e'(regWrData[`AFQ_CFG_MODE_HI:`AFQ_CFG_MODE_LO]);
         cfgAxis <= afq_pkg::afq_axis_e'(regWrData[`AFQ_CFG_SEL_HI:`AFQ_CFG_SEL_LO]);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         compStartZ <= 1'b0;
      end else begin
         compStartZ <= compTrigger == afq_pkg::AFQ_COMP_Z && compReady; // (R19)
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         zFiltTrimmed <= '0;
         zRawTrimmed  <= '0;
      end else begin
         zFiltTrimmed <= addTrim(accZFilt, zTrim, accRange); // (R1)
         zRawTrimmed  <= addTrim(accZRaw, zTrim, accRange); // (R1)
      end
   end

   always_ff @(posedge core_clk) begin
      if (memWe) begin
         frameMem[memAddr] <= packFrame(cfgAxis, ingData); // (R12)
      end
   end

   // push and pop never meet: push is held off whenever a pop can occur
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdPtr      <= '0;
         wrPtr      <= '0;
         queueLevel <= '0;
      end else if (clearQ) begin
         rdPtr      <= '0; // (R7)
         wrPtr      <= '0;
         queueLevel <= '0;
      end else if (popNow) begin
         rdPtr      <= `AFQ_PTR_W'(rdPtr + 1'b1); // (R21)
         queueLevel <= `AFQ_LVL_W'(queueLevel - 1'b1);
      end else if (push) begin
         unique case (cfgMode)
            afq_pkg::AFQ_HOLD_FULL: begin
               if (!queueAtTop) begin
                  wrPtr      <= `AFQ_PTR_W'(wrPtr + 1'b1); // (R9)
                  queueLevel <= `AFQ_LVL_W'(queueLevel + 1'b1);
               end
            end
            afq_pkg::AFQ_CONTINUOUS_OVERWRITE: begin
               wrPtr <= `AFQ_PTR_W'(wrPtr + 1'b1); // (R10)
               if (queueAtTop) begin
                  rdPtr <= `AFQ_PTR_W'(rdPtr + 1'b1); // (R10)
               end else begin
                  queueLevel <= `AFQ_LVL_W'(queueLevel + 1'b1);
               end
            end
            // reserved code is never written by software; it behaves as the one-frame mode
            default: begin
               wrPtr      <= `AFQ_PTR_W'(rdPtr + 1'b1); // (R8) (R11)
               queueLevel <= `AFQ_LVL_W'(1);
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         byteIdx <= 3'd0;
      end else if (clearQ || popNow) begin
         byteIdx <= 3'd0; // (R15)
      end else if (dataRead) begin
         byteIdx <= byteIdx + 3'd1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         queueFull <= 1'b0;
      end else if (clearQ) begin
         queueFull <= 1'b0; // (R7)
      end else if (queueAtTop) begin
         queueFull <= 1'b1; // (R20)
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addrHold <= 1'b0;
      end else if (burstEnd) begin
         addrHold <= 1'b0;
      end else if (regRdEn && regAddr == `AFQ_ADDR_DATA) begin
         addrHold <= 1'b1; // (R14)
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= `AFQ_RST_BYTE;
      end else if (regRdEn) begin
         case (regAddr)
            `AFQ_ADDR_ZTRIM: regRdData <= zTrim;
            `AFQ_ADDR_SCR0:  regRdData <= scratchByteZero;
            `AFQ_ADDR_SCR1:  regRdData <= scratchByteOne;
            `AFQ_ADDR_CFG:   regRdData <= {cfgMode, 4'h0, cfgAxis};
            `AFQ_ADDR_DATA:  regRdData <= (queueLevel != '0) ? frameByte(frameMem[rdPtr], cfgAxis, byteIdx)
                                                           : `AFQ_RST_BYTE; // (R21) (R13)
            default:         regRdData <= `AFQ_RST_BYTE;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_partial_end;
      burstEnd && frameBusy && !dataRead;
   endsequence
   sequence s_last_read;
      dataRead && lastByte;
   endsequence

   a_cfg_write_clears: assert property (cfgWrite |=> queueLevel == '0 && !queueFull) // (R7)
      else $error("config write left data or full flag");
   a_bypass_one_frame: assert property (cfgMode == afq_pkg::AFQ_BYPASS |-> queueLevel <= 6'd1) // (R8)
      else $error("one-frame mode holds more than one frame");
   a_hold_refuses_more: assert property (cfgMode == afq_pkg::AFQ_HOLD_FULL && queueAtTop && push
      |=> queueLevel == `AFQ_DEPTH && $stable(wrPtr)) // (R9)
      else $error("stop-when-full mode accepted a frame");
   a_overwrite_oldest: assert property (cfgMode == afq_pkg::AFQ_CONTINUOUS_OVERWRITE && queueAtTop && push
      |=> rdPtr == `AFQ_PTR_W'($past(rdPtr) + 1'b1) && queueAtTop) // (R10)
      else $error("overwrite mode did not drop the oldest frame");
   a_full_sticky: assert property (queueFull && !clearQ |=> queueFull) // (R20)
      else $error("full flag dropped without config write");
   a_full_rises: assert property (queueAtTop && !clearQ |=> queueFull) // (R20)
      else $error("full flag missing at 32 frames");
   a_empty_reads_zero: assert property (regRdEn && regAddr == `AFQ_ADDR_DATA && queueLevel == '0
      |=> regRdData == 8'h00) // (R21)
      else $error("empty queue read returned data");
   a_frame_frees_slot: assert property (s_last_read |=> queueLevel == `AFQ_LVL_W'($past(queueLevel) - 1'b1)
      && byteIdx == 3'd0) // (R21)
      else $error("complete frame read did not free a slot");
   a_partial_discard: assert property (s_partial_end |=> byteIdx == 3'd0
      && rdPtr == `AFQ_PTR_W'($past(rdPtr) + 1'b1)) // (R15)
      else $error("partly read frame not discarded");
   a_nv_restore: assert property (restorePending |=> zTrim == $past(nvmZTrim)
      && scratchByteZero == $past(nvmScratchZero) && scratchByteOne == $past(nvmScratchOne)) // (R3)
      else $error("nv images not restored after reset");
   a_offset_clear: assert property (offsetClear && !restorePending && !softReset |=> zTrim == 8'h00) // (R18)
      else $error("offset clear left z trim nonzero");
   a_burst_holds: assert property (regRdEn && regAddr == `AFQ_ADDR_DATA && !burstEnd |=> addrHold) // (R14)
      else $error("address hold missing for data burst");
   a_comp_start: assert property (compTrigger == afq_pkg::AFQ_COMP_Z |=> compStartZ == $past(compReady)) // (R19)
      else $error("z compensation start mismatch");
endmodule

// >>> tb/afq_host_model.sv
// host model driving the register port: writes, fixed-address read bursts, transaction ends
`timescale 1ns/1ns
`include "afq_consts.svh"
module afq_host_model (
   input  wire logic       core_clk,
   output logic      [7:0] regAddr,
   output logic            regWrEn,
   output logic      [7:0] regWrData,
   output logic            regRdEn,
   output logic            burstEnd
);
   initial begin
      {regAddr, regWrData} = 16'h0000;
      {regWrEn, regRdEn, burstEnd} = 3'h0;
   end
   // idle lines show the inverse of the last value so nothing leans on a stale byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regAddr = a;
      regWrData = (a == `AFQ_ADDR_CFG && d[7:6] == 2'b11) ? {2'b00, d[5:0]} : d;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~regWrData;
   endtask
   task automatic rdBurst(input logic [7:0] a, input int n);
      @(negedge core_clk);
      regAddr = a;
      regRdEn = 1'b1;
      repeat (n) @(negedge core_clk);
      regRdEn = 1'b0;
      regAddr = ~a;
   endtask
   task automatic endB();
      @(negedge core_clk) burstEnd = 1'b1;
      @(negedge core_clk) burstEnd = 1'b0;
   endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the accel queue and trim block
`timescale 1ns/1ns
`include "afq_consts.svh"
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   logic        core_clk, rst_n, softReset, offsetClear, compReady, compZDone, sampleValid;
   logic [7:0]  nvmZTrim, nvmScratchZero, nvmScratchOne, compZValue, regAddr, regWrData, regRdData;
   logic [7:0]  zTrim, scratchByteZero, scratchByteOne, eb, mb;
   logic        regWrEn, regRdEn, burstEnd, addrHold, compStartZ, sampleReady, queueFull, rdLate;
   logic [1:0]  compTrigger, accRange;
   logic [11:0] accZFilt, accZRaw, zFiltTrimmed, zRawTrimmed;
   logic [15:0] sampleX, sampleY, sampleZ;
   logic [5:0]  queueLevel;
   logic [47:0] frm[$];
   logic [7:0]  expQ[$];
   int          errors, testsRun;
   afq_core i_afq_core (
      .core_clk, .rst_n, .softReset, .nvmZTrim, .nvmScratchZero, .nvmScratchOne, .regAddr, .regWrEn,
      .regWrData, .regRdEn, .burstEnd, .regRdData, .addrHold, .offsetClear, .compTrigger, .compReady,
      .compZDone, .compZValue, .compStartZ, .accRange, .accZFilt, .accZRaw, .zFiltTrimmed, .zRawTrimmed,
      .sampleValid, .sampleReady, .sampleX, .sampleY, .sampleZ, .zTrim, .scratchByteZero,
      .scratchByteOne, .queueFull, .queueLevel
   );
   afq_host_model i_afq_host_model (.core_clk, .regAddr, .regWrEn, .regWrData, .regRdEn, .burstEnd);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (rdLate === 1'b1) begin
         mb = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
         `CHK(regRdData, mb)
      end
      rdLate <= regRdEn;
   end
   function automatic logic [11:0] expTrim(input logic [11:0] d, input logic [7:0] t, input logic [1:0] r);
      int s;
      s = $signed(d) + $signed(t) * (1 << (3 - int'(r)));
      if (s > 2047) s = 2047;
      if (s < -2048) s = -2048;
      return 12'(s);
   endfunction
   task automatic rd1(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      i_afq_host_model.rdBurst(a, 1);
   endtask
   task automatic waitLvl(input logic [5:0] e);
      for (int w = 0; w < 100 && queueLevel !== e; w++) @(negedge core_clk);
      `CHK(queueLevel, e)
   endtask
   task automatic pushFrames(input int n);
      logic [47:0] f;
      int          w;
      for (int i = 0; i < n; i++) begin
         f = {16'($urandom), 32'($urandom)};
         frm.push_back(f);
         @(negedge core_clk);
         {sampleZ, sampleY, sampleX} = f;
         sampleValid = 1'b1;
         w = 0;
         do begin
            @(posedge core_clk);
            w++;
         end while (sampleReady !== 1'b1 && w < 100);
         `CHK(sampleReady, 1'b1)
      end
      @(negedge core_clk);
      sampleValid = 1'b0;
      {sampleZ, sampleY, sampleX} = ~f;
   endtask
   task automatic readFrames(input logic [1:0] ax, input int n);
      logic [47:0] f;
      int          nb;
      nb = (ax == 2'b00) ? 6 : 2;
      for (int i = 0; i < n; i++) begin
         f = frm.pop_front();
         for (int k = 0; k < nb; k++) expQ.push_back((ax == 2'b00) ? f[8*k+:8] : f[16*(int'(ax)-1)+8*k+:8]);
      end
      i_afq_host_model.rdBurst(`AFQ_ADDR_DATA, nb * n);
      `CHK(addrHold, 1'b1)
      i_afq_host_model.endB();
      @(negedge core_clk);
      `CHK(addrHold, 1'b0)
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic printVerdict();
      $display("checks %0d, mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // generous bound: the full sequence needs only a few hundred cycles
   initial begin
      #1000000;
      errors++;
      printVerdict();
   end
   initial begin
      void'($urandom(32'ha3da));
      rst_n = 1'b0;
      rdLate = 1'b0;
      {softReset, offsetClear, compReady, compZDone, sampleValid, compTrigger, accRange} = 9'h000;
      {accZFilt, accZRaw, sampleX, sampleY, sampleZ} = 72'h0;
      {nvmZTrim, nvmScratchZero, nvmScratchOne, compZValue} = $urandom;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk) rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      rd1(`AFQ_ADDR_ZTRIM, nvmZTrim);
      rd1(`AFQ_ADDR_SCR0, nvmScratchZero);
      rd1(`AFQ_ADDR_SCR1, nvmScratchOne);
      rd1(`AFQ_ADDR_CFG, `AFQ_RST_BYTE);
      rd1(8'h3d, 8'h00);
      rd1(`AFQ_ADDR_DATA, 8'h00);
      for (int a = 8'h3a; a <= 8'h3c; a++) begin
         eb = 8'($urandom);
         i_afq_host_model.wr(8'(a), eb);
         rd1(8'(a), eb);
      end
      `CHK(scratchByteOne, eb)
      i_afq_host_model.wr(`AFQ_ADDR_CFG, 8'h7d);
      rd1(`AFQ_ADDR_CFG, 8'h41);
      done("registers");
      @(negedge core_clk) offsetClear = 1'b1;
      @(negedge core_clk) offsetClear = 1'b0;
      rd1(`AFQ_ADDR_ZTRIM, 8'h00);
      compZValue = 8'($urandom);
      compZDone = 1'b1;
      @(negedge core_clk) compZDone = 1'b0;
      rd1(`AFQ_ADDR_ZTRIM, compZValue);
      compReady = 1'b1;
      for (int c = 0; c < 4; c++) begin
         compTrigger = 2'(c);
         @(negedge core_clk) compTrigger = 2'b00;
         `CHK(compStartZ, 1'(c == 3))
         @(negedge core_clk);
      end
      `CHK(compStartZ, 1'b0)
      done("trim control");
      for (int i = 0; i < 6; i++) begin
         eb = (i == 4) ? 8'h7f : (i == 5) ? 8'h80 : 8'($urandom);
         i_afq_host_model.wr(`AFQ_ADDR_ZTRIM, eb);
         accRange = 2'(i);
         accZFilt = (i == 4) ? 12'h7ff : 12'($urandom);
         accZRaw = (i == 5) ? 12'h800 : 12'($urandom);
         @(negedge core_clk);
         `CHK(zFiltTrimmed, expTrim(accZFilt, eb, accRange))
         `CHK(zRawTrimmed, expTrim(accZRaw, eb, accRange))
      end
      done("trim arithmetic");
      for (int ax = 0; ax < 4; ax++) begin
         i_afq_host_model.wr(`AFQ_ADDR_CFG, {6'h10, 2'(ax)});
         pushFrames(2);
         waitLvl(6'd2);
         readFrames(2'(ax), 2);
         waitLvl(6'd0);
      end
      done("axis order");
      i_afq_host_model.wr(`AFQ_ADDR_CFG, 8'h40);
      pushFrames(40);
      frm = frm[0:31];
      repeat (12) @(negedge core_clk);
      waitLvl(6'd32);
      `CHK(queueFull, 1'b1)
      readFrames(2'b00, 1);
      `CHK(queueFull, 1'b1)
      i_afq_host_model.wr(`AFQ_ADDR_CFG, 8'h80);
      waitLvl(6'd0);
      `CHK(queueFull, 1'b0)
      done("hold full");
      frm.delete();
      pushFrames(34);
      repeat (12) @(negedge core_clk);
      frm = frm[2:33];
      waitLvl(6'd32);
      readFrames(2'b00, 1);
      done("overwrite");
      i_afq_host_model.wr(`AFQ_ADDR_CFG, 8'h03);
      frm.delete();
      pushFrames(3);
      repeat (12) @(negedge core_clk);
      frm = frm[2:2];
      waitLvl(6'd1);
      readFrames(2'b11, 1);
      done("bypass");
      i_afq_host_model.wr(`AFQ_ADDR_CFG, 8'h40);
      pushFrames(2);
      waitLvl(6'd2);
      for (int k = 0; k < 3; k++) expQ.push_back(frm[0][8*k+:8]);
      i_afq_host_model.rdBurst(`AFQ_ADDR_DATA, 3);
      i_afq_host_model.endB();
      waitLvl(6'd1);
      frm = frm[1:1];
      readFrames(2'b00, 1);
      done("partial frame");
      {nvmZTrim, nvmScratchZero, nvmScratchOne, compZValue} = $urandom;
      softReset = 1'b1;
      @(negedge core_clk) softReset = 1'b0;
      rd1(`AFQ_ADDR_ZTRIM, nvmZTrim);
      rd1(`AFQ_ADDR_SCR0, nvmScratchZero);
      rd1(`AFQ_ADDR_SCR1, nvmScratchOne);
      rd1(`AFQ_ADDR_CFG, 8'h00);
      `CHK(zTrim, nvmZTrim)
      `CHK(scratchByteZero, nvmScratchZero)
      @(negedge core_clk);
      done("soft reset");
      printVerdict();
   end
endmodule
